//--- rtl/sbs_pkg.sv
// package for the burst sram control port: widths, reset values, codes
// assumes one rising-edge clock that samples every synchronous input
//
// Overview of operation
// - address captured only when a strobe is low and all enables active
// - capture loads the two low address bits into the burst counter
// - lane-select writes happen only when the lane qualifier is sampled low
// - all-lanes write low writes every lane, ignoring selects and qualifier, except on a cpu-strobe load
// - inputs sampled on rising edge; counter steps when advance is low
// - enable one is active low; cpu strobe ignored while it is high
// - enable two is active high and joins the other enables
// - enables sampled only on cycles that load an external address
// - both strobes low: cpu strobe acts, controller strobe ignored
// - advance low during a burst steps to next burst address each edge
// - order strap low gives linear bursts, high gives interleaved
// - output enable masked on first read clock after deselect
package sbs_pkg;
    localparam int SBS_ADDR_W = 18;
    localparam int SBS_LANES = 4;
    localparam logic [1:0] SBS_CNT_RST = 2'h0;
    localparam logic [1:0] SBS_CNT_STEP = 2'h1;
    localparam logic [SBS_LANES-1:0] SBS_LANES_ALL = 4'hF;
    localparam logic [SBS_LANES-1:0] SBS_LANES_NONE = 4'h0;
    localparam logic SBS_ORDER_LINEAR = 1'b0;

    typedef enum logic [1:0]
    {
        SBS_ST_DESEL = 2'b00,
        SBS_ST_READ = 2'b01,
        SBS_ST_WRITE = 2'b10
    } sbs_state_e;

    typedef struct packed
    {
        logic cpu_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic chip_en1_n;
        logic chip_en2;
        logic chip_en3_n;
    } sbs_ctl_s;

    typedef struct packed
    {
        logic all_lanes_write_n;
        logic lane_write_qualify_n;
        logic lane_d_write_sel_n;
        logic lane_c_write_sel_n;
        logic lane_b_write_sel_n;
        logic lane_a_write_sel_n;
    } sbs_wr_s;
endpackage

//--- rtl/sbs_strap_sync.sv
// three-stage synchroniser for the static burst-order strap
// assumes the strap is steady in operation; reset value is interleaved
`timescale 1ns/1ps
`default_nettype none
module sbs_strap_sync
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // strap in and filtered out
    input wire logic strap_in,
    output logic strap_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            strap_out <= 1'b1;
        end
        else
        begin
            s1_reg <= strap_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
            begin
                strap_out <= s3_reg;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/sbs_ctrl_port.sv
// control-input port of a pipelined synchronous burst sram
// assumes the far controller drives all synchronous inputs on mclk
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_port
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // address and control inputs
    input wire logic [SBS_ADDR_W-1:0] addr_in,
    input wire sbs_ctl_s ctl_in,
    input wire sbs_wr_s wr_in,
    input wire logic burst_order_strap,
    // array side outputs
    output logic [SBS_ADDR_W-1:0] array_addr,
    output logic [SBS_LANES-1:0] lane_write_en,
    output logic selected,
    output logic oe_mask
);
    //--------------------------------------------------
    // strobe qualification
    //--------------------------------------------------
    logic order_linear;
    logic cpu_load;
    logic ctrl_load;
    logic load;
    logic enables_ok;
    logic [SBS_ADDR_W-1:0] base_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    sbs_state_e state_reg;
    sbs_state_e state_next;
    logic [SBS_LANES-1:0] sel_lanes;
    logic [SBS_LANES-1:0] wr_next;
    logic order_strap_sync;

    sbs_strap_sync u_sbs_strap_sync
    (
        .mclk(mclk),
        .rstn(rstn),
        .strap_in(burst_order_strap),
        .strap_out(order_strap_sync)
    );
    assign order_linear = (order_strap_sync == SBS_ORDER_LINEAR);

    assign enables_ok = !ctl_in.chip_en1_n && ctl_in.chip_en2 && !ctl_in.chip_en3_n;
    assign cpu_load = !ctl_in.cpu_addr_strobe_n && !ctl_in.chip_en1_n;
    assign ctrl_load = !ctl_in.ctrl_addr_strobe_n && ctl_in.cpu_addr_strobe_n;
    assign load = cpu_load || ctrl_load;

    //--------------------------------------------------
    // address register and burst counter
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            base_reg <= '0;
        end
        else if (load && enables_ok)
        begin
            base_reg <= addr_in;
        end
    end

    always_comb
    begin
        cnt_next = cnt_reg;
        if (load && enables_ok)
        begin
            cnt_next = addr_in[1:0];
        end
        else if (!load && !ctl_in.burst_advance_n && state_reg != SBS_ST_DESEL)
        begin
            cnt_next = cnt_reg + SBS_CNT_STEP;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg <= SBS_CNT_RST;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // linear adds the count, interleaved xors it into the start bits
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            array_addr <= '0;
        end
        else if (order_linear)
        begin
            array_addr <= {(load && enables_ok) ? addr_in[SBS_ADDR_W-1:2]
                           : base_reg[SBS_ADDR_W-1:2], cnt_next};
        end
        else
        begin
            array_addr <= {(load && enables_ok) ? addr_in[SBS_ADDR_W-1:2]
                           : base_reg[SBS_ADDR_W-1:2],
                           ((load && enables_ok) ? addr_in[1:0] : base_reg[1:0])
                           ^ (cnt_next - ((load && enables_ok) ? addr_in[1:0]
                           : base_reg[1:0]))};
        end
    end

    //--------------------------------------------------
    // select state and output-enable mask
    //--------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        if (load)
        begin
            if (!enables_ok)
            begin
                state_next = SBS_ST_DESEL;
            end
            else if (ctrl_load && (!wr_in.all_lanes_write_n || !wr_in.lane_write_qualify_n))
            begin
                state_next = SBS_ST_WRITE;
            end
            else
            begin
                state_next = SBS_ST_READ;
            end
        end
        else if (state_reg != SBS_ST_DESEL)
        begin
            state_next = (!wr_in.all_lanes_write_n || !wr_in.lane_write_qualify_n)
                         ? SBS_ST_WRITE : SBS_ST_READ;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= SBS_ST_DESEL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            oe_mask <= 1'b1;
        end
        else
        begin
            oe_mask <= (state_reg == SBS_ST_DESEL) && (state_next != SBS_ST_WRITE);
        end
    end

    assign selected = (state_reg != SBS_ST_DESEL);

    //--------------------------------------------------
    // lane write qualification
    //--------------------------------------------------
    generate
        for (genvar i = 0; i < SBS_LANES; i++)
        begin : g_lane
            assign sel_lanes[i] = !wr_in[i] && !wr_in.lane_write_qualify_n;
        end
    endgenerate

    always_comb
    begin
        wr_next = SBS_LANES_NONE;
        if (state_next == SBS_ST_WRITE)
        begin
            if (!wr_in.all_lanes_write_n)
            begin
                wr_next = SBS_LANES_ALL;
            end
            else
            begin
                wr_next = sel_lanes;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lane_write_en <= SBS_LANES_NONE;
        end
        else
        begin
            lane_write_en <= wr_next;
        end
    end

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    AST_NO_LOAD_WHEN_DESEL: assert property (@(posedge mclk) disable iff (!rstn)
        (load && !enables_ok) |=> (state_reg == SBS_ST_DESEL))
        else $error("deselect not taken");
    AST_LOAD_COUNTER: assert property (@(posedge mclk) disable iff (!rstn)
        (load && enables_ok) |=> (cnt_reg == $past(addr_in[1:0])))
        else $error("counter not loaded");
    AST_GLOBAL_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        (state_next == SBS_ST_WRITE && !wr_in.all_lanes_write_n)
        |=> (lane_write_en == SBS_LANES_ALL))
        else $error("global write missed lanes");
    AST_QUALIFY: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_in.all_lanes_write_n && wr_in.lane_write_qualify_n)
        |=> (lane_write_en == SBS_LANES_NONE))
        else $error("unqualified lane write");
    AST_ADVANCE: assert property (@(posedge mclk) disable iff (!rstn)
        (!load && !ctl_in.burst_advance_n && selected)
        |=> (cnt_reg == $past(cnt_reg) + SBS_CNT_STEP))
        else $error("burst did not advance");
    AST_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        (!load && ctl_in.burst_advance_n) |=> $stable(cnt_reg))
        else $error("burst address moved");
    AST_CPU_IGNORED: assert property (@(posedge mclk) disable iff (!rstn)
        (ctl_in.chip_en1_n && ctl_in.ctrl_addr_strobe_n) |-> !load)
        else $error("cpu strobe not ignored");
    AST_PRIORITY: assert property (@(posedge mclk) disable iff (!rstn)
        (!ctl_in.cpu_addr_strobe_n && !ctl_in.ctrl_addr_strobe_n) |-> !ctrl_load)
        else $error("controller strobe acted");
    AST_OE_MASK: assert property (@(posedge mclk) disable iff (!rstn)
        (!selected && state_next == SBS_ST_READ) |=> oe_mask ##1 1'b1)
        else $error("output enable not masked");
endmodule
`default_nettype wire

//--- tb/sbs_host_model.sv
// far-side controller model: drives every synchronous input of the port
// assumes the bench calls put just after a falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model
    import sbs_pkg::*;
(
    // bus towards the port
    output logic [SBS_ADDR_W-1:0] addr,
    output sbs_ctl_s ctl,
    output sbs_wr_s wr,
    output logic strap
);
    initial
    begin
        addr = 18'h00000;
        ctl = 6'h3A;
        wr = 6'h3F;
        strap = 1'b0;
    end

    // one bus cycle; the lane qualifier or all-lanes write goes low to ask for a write
    task automatic put(input logic [SBS_ADDR_W-1:0] a, input logic [5:0] c, input logic [5:0] w);
        addr = a;
        ctl = c;
        wr = w;
    endtask

    // strap change; the port filters it through its synchroniser
    task automatic set_strap(input logic s);
        strap = s;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// bench for the burst sram control port: one task per scenario
// assumes inputs change at the falling edge and outputs settle by the next
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbs_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [SBS_ADDR_W-1:0] addr_in;
    sbs_ctl_s ctl_in;
    sbs_wr_s wr_in;
    logic strap;
    logic [SBS_ADDR_W-1:0] array_addr;
    logic [SBS_LANES-1:0] lane_write_en;
    logic selected;
    logic oe_mask;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    sbs_host_model u_sbs_host_model (.addr(addr_in), .ctl(ctl_in), .wr(wr_in), .strap(strap));

    sbs_ctrl_port u_sbs_ctrl_port (.mclk(mclk), .rstn(rstn), .addr_in(addr_in),
        .ctl_in(ctl_in), .wr_in(wr_in), .burst_order_strap(strap),
        .array_addr(array_addr), .lane_write_en(lane_write_en),
        .selected(selected), .oe_mask(oe_mask));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks run %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one sampling edge, outputs read at the following falling edge
    task automatic cyc(input logic [17:0] a, input logic [5:0] c, input logic [5:0] w);
        u_sbs_host_model.put(a, c, w);
        @(negedge mclk);
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            print_verdict;
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_capture_burst;
        cyc(18'h12343, 6'h2A, 6'h1F);
        chk("addr", array_addr, 18'h12343);
        chk("lanes", 18'(lane_write_en), 18'h0000F);
        chk("sel", 18'(selected), 18'h00001);
        cyc(18'h00000, 6'h32, 6'h3F);
        chk("step", array_addr, 18'h12340);
        cyc(18'h3FFFF, 6'h3A, 6'h3F);
        chk("hold", array_addr, 18'h12340);
    endtask

    task automatic t_ignored;
        cyc(18'h05555, 6'h1E, 6'h3F);
        chk("cpu ign", array_addr, 18'h12340);
        chk("cpu sel", 18'(selected), 18'h00001);
        cyc(18'h00000, 6'h38, 6'h3F);
        chk("en noload", 18'(selected), 18'h00001);
    endtask

    task automatic t_byte_and_both;
        cyc(18'h00100, 6'h2A, 6'h2E);
        chk("qual lane", 18'(lane_write_en), 18'h00001);
        cyc(18'h00100, 6'h2A, 6'h3E);
        chk("no qual", 18'(lane_write_en), 18'h00000);
        cyc(18'h00208, 6'h0A, 6'h1F);
        chk("both addr", array_addr, 18'h00208);
        chk("both rd", 18'(lane_write_en), 18'h00000);
        // write following a cpu-strobe load, lanes d and c selected
        cyc(18'h00000, 6'h3A, 6'h23);
        chk("cont lanes", 18'(lane_write_en), 18'h0000C);
        chk("cont addr", array_addr, 18'h00208);
    endtask

    task automatic t_deselect_oe;
        cyc(18'h00000, 6'h28, 6'h3F);
        chk("desel", 18'(selected), 18'h00000);
        cyc(18'h00400, 6'h1A, 6'h3F);
        chk("oe first", 18'(oe_mask), 18'h00001);
        chk("resel", 18'(selected), 18'h00001);
        cyc(18'h00000, 6'h3A, 6'h3F);
        chk("oe next", 18'(oe_mask), 18'h00000);
    endtask

    task automatic t_interleaved;
        u_sbs_host_model.set_strap(1'b1);
        repeat (6) @(negedge mclk);
        cyc(18'h00011, 6'h2A, 6'h3F);
        chk("ilv 0", array_addr, 18'h00011);
        cyc(18'h00000, 6'h32, 6'h3F);
        chk("ilv 1", array_addr, 18'h00010);
        cyc(18'h00000, 6'h32, 6'h3F);
        chk("ilv 2", array_addr, 18'h00013);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(negedge mclk);
        chk("rst addr", array_addr, 18'h00000);
        chk("rst lanes", 18'(lane_write_en), 18'h00000);
        chk("rst sel", 18'(selected), 18'h00000);
        chk("rst oe", 18'(oe_mask), 18'h00001);
        rstn = 1'b1;
        // strap synchroniser leaves reset interleaved; let it settle to linear
        repeat (4) @(negedge mclk);
        chk("idle sel", 18'(selected), 18'h00000);
        t_capture_burst;
        t_ignored;
        t_byte_and_both;
        t_deselect_oe;
        t_interleaved;
        print_verdict;
    end
endmodule
`default_nettype wire
